// File: rtl/pdt_regs.svh
`ifndef PDT_REGS_SVH
`define PDT_REGS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define PDT_OFS_CTRL 8'h00
`define PDT_OFS_PAT_VALUE 8'h04
`define PDT_OFS_PAT_MASK 8'h08
`define PDT_OFS_LONGER 8'h0c
`define PDT_OFS_SHORTER 8'h10
`define PDT_OFS_WIN_LO 8'h14
`define PDT_OFS_WIN_HI 8'h18
`define PDT_OFS_BURST_ORD 8'h1c
`define PDT_OFS_BURST_IDLE 8'h20
`define PDT_OFS_STATUS 8'h24
`define PDT_OFS_TRIG_CNT 8'h28

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define PDT_CTRL_EN_BIT 0
`define PDT_CTRL_MODE_BIT 1
`define PDT_CTRL_QUAL_LSB 2
`define PDT_CTRL_QUAL_MSB 4
`define PDT_CTRL_POL_BIT 5
`define PDT_CTRL_SRC_LSB 8
`define PDT_CTRL_SRC_MSB 12
`define PDT_CTRL_RST 32'h0000_0000
`define PDT_BURST_ORD_RST 32'h0000_0001

// ----------------------------------------------------------------
// timing: clock period and documented time limits
// ----------------------------------------------------------------
`define PDT_CLK_PERIOD_NS 50
`define PDT_CYC_PER_MS (1000000 / `PDT_CLK_PERIOD_NS)
`define PDT_LONGER_MIN_NS 5
`define PDT_LONGER_MAX_MS 10000
`define PDT_SHORTER_MIN_NS 5
`define PDT_SHORTER_MAX_MS 10000
`define PDT_WIN_LO_MIN_NS 10
`define PDT_WIN_LO_MAX_MS 9990
`define PDT_WIN_HI_MIN_NS 15
`define PDT_WIN_HI_MAX_MS 10000
`define PDT_IDLE_MIN_NS 10
`define PDT_IDLE_MAX_MS 10000

`endif

// File: rtl/pdt_pkg.sv
package pdt_pkg;
    // duration qualifier selections
    typedef enum logic [2:0] {
        PDT_QUAL_LONGER,
        PDT_QUAL_SHORTER,
        PDT_QUAL_WITHIN,
        PDT_QUAL_OUTSIDE,
        PDT_QUAL_TIMEOUT
    } pdt_qual_t;
    // channel layout of the instrument variant
    typedef enum logic [1:0] {
        PDT_VAR_4A16D,
        PDT_VAR_2A16D,
        PDT_VAR_4A,
        PDT_VAR_2A
    } pdt_variant_t;
endpackage

// File: rtl/pdt_sync.sv
// ----------------------------------------------------------------
// two-stage synchroniser for asynchronous pin levels
// ----------------------------------------------------------------
module pdt_sync #(
    parameter int WIDTH = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta; // first stage, read only by second stage

    // both stages reset to low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// File: rtl/pdt_trigger.sv
// Summary of operation
// - 4A+16D: bits0-15 digital, 16-19 analog
// - 2A+16D: bits0-15 digital, 16-17 analog
// - 4A only: bits0-3 analog, bit4 external
// - 2A only: bits0-1 analog, bit4 external
// - value bit sets required channel level
// - mask zero excludes channel from match
// - value and mask held 32-bit, readable
// - five duration qualifiers selectable
// - timeout reuses the longer-than limit
// - window bounds clamped to their ranges
// - window used only by window qualifiers
// - lower above upper swaps the bounds
// - trigger on edge number equal ordinal
// - burst edges from selected source channel
// - longer limit is minimum true time
// - true time must stay below shorter limit
// - idle quiet time restarts edge count
// - polarity picks rising or falling edges
`include "pdt_regs.svh"

module pdt_trigger
    import pdt_pkg::*;
#(
    parameter pdt_variant_t VARIANT = PDT_VAR_4A16D,
    parameter logic [31:0] LONGER_MAX_CYC =
        32'(`PDT_LONGER_MAX_MS * `PDT_CYC_PER_MS),
    parameter logic [31:0] SHORTER_MAX_CYC =
        32'(`PDT_SHORTER_MAX_MS * `PDT_CYC_PER_MS),
    parameter logic [31:0] WIN_LO_MAX_CYC =
        32'(`PDT_WIN_LO_MAX_MS * `PDT_CYC_PER_MS),
    parameter logic [31:0] WIN_HI_MAX_CYC =
        32'(`PDT_WIN_HI_MAX_MS * `PDT_CYC_PER_MS),
    parameter logic [31:0] IDLE_MAX_CYC =
        32'(`PDT_IDLE_MAX_MS * `PDT_CYC_PER_MS)
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [15:0] dig_in,
    input wire logic [3:0] ana_in,
    input wire logic ext_in,
    output logic trig_out
);
    // ------------------------------------------------------------
    // cycle counts derived from the time limits
    // ------------------------------------------------------------
    function automatic logic [31:0] min_cyc(input int ns);
        int c;
        c = (ns + `PDT_CLK_PERIOD_NS - 1) / `PDT_CLK_PERIOD_NS;
        if (c < 1) begin
            c = 1;
        end
        return 32'(c);
    endfunction

    function automatic logic [31:0] clamp(input logic [31:0] v,
        input logic [31:0] lo, input logic [31:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    localparam logic [31:0] LONGER_MIN_CYC = min_cyc(`PDT_LONGER_MIN_NS);
    localparam logic [31:0] SHORTER_MIN_CYC = min_cyc(`PDT_SHORTER_MIN_NS);
    localparam logic [31:0] WIN_LO_MIN_CYC = min_cyc(`PDT_WIN_LO_MIN_NS);
    localparam logic [31:0] WIN_HI_MIN_CYC = min_cyc(`PDT_WIN_HI_MIN_NS);
    localparam logic [31:0] IDLE_MIN_CYC = min_cyc(`PDT_IDLE_MIN_NS);

    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    logic [31:0] ctrl; // enable, mode, qualifier, polarity, source
    logic [31:0] pat_value; // required channel levels
    logic [31:0] pat_mask; // channels taking part
    logic [31:0] longer_lim; // also the timeout limit
    logic [31:0] shorter_lim; // accepted true time is below this
    logic [31:0] win_lo; // window lower bound, cycles
    logic [31:0] win_hi; // window upper bound, cycles
    logic [31:0] burst_ord; // edge ordinal that fires
    logic [31:0] burst_idle; // quiet time that ends a burst
    logic [31:0] trig_cnt; // triggers since reset
    logic [31:0] dur_cnt; // matched samples so far
    logic [31:0] edge_cnt; // qualifying edges in this burst
    logic [31:0] idle_cnt; // cycles since last source transition
    logic src_prev; // source level one sample ago
    logic [20:0] pins_sync; // synchronised pin levels
    logic [31:0] chan; // pin levels in pattern bit order
    logic pat_match;
    logic next_trig;
    logic trig_en;
    logic burst_mode;
    pdt_qual_t qual;
    logic pol_rise;
    logic src_now;
    logic src_trans;
    logic edge_hit;
    logic idle_done;
    logic [31:0] next_edge_cnt;
    logic match_end;
    logic [32:0] dur_plus;
    logic [31:0] rd_mux;
    logic addr_ok;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr_q;
    logic [31:0] new_lo;
    logic [31:0] new_hi;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    pdt_sync #(
        .WIDTH(21)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in({ext_in, ana_in, dig_in}),
        .sync_out(pins_sync)
    );

    // map pins onto pattern bits; unused bits read as low
    always_comb begin
        chan = '0;
        case (VARIANT)
            PDT_VAR_4A16D: begin
                chan[15:0] = pins_sync[15:0];
                chan[19:16] = pins_sync[19:16];
            end
            PDT_VAR_2A16D: begin
                chan[15:0] = pins_sync[15:0];
                chan[17:16] = pins_sync[17:16];
            end
            PDT_VAR_4A: begin
                chan[3:0] = pins_sync[19:16];
                chan[4] = pins_sync[20];
            end
            default: begin
                chan[1:0] = pins_sync[17:16];
                chan[4] = pins_sync[20];
            end
        endcase
    end

    // ------------------------------------------------------------
    // decoded control fields
    // ------------------------------------------------------------
    assign trig_en = ctrl[`PDT_CTRL_EN_BIT];
    assign burst_mode = ctrl[`PDT_CTRL_MODE_BIT];
    assign qual = pdt_qual_t'(ctrl[`PDT_CTRL_QUAL_MSB:`PDT_CTRL_QUAL_LSB]);
    assign pol_rise = ctrl[`PDT_CTRL_POL_BIT];

    // each masked-in channel must sit at its value bit
    assign pat_match = &(~pat_mask | ~(chan ^ pat_value));

    // ------------------------------------------------------------
    // pattern duration timing
    // ------------------------------------------------------------
    // counter saturates so very long patterns never wrap to short
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dur_cnt <= '0;
        end else if (!pat_match) begin
            dur_cnt <= '0;
        end else if (dur_cnt != 32'hffff_ffff) begin
            dur_cnt <= dur_cnt + 32'h0000_0001;
        end
    end

    assign match_end = !pat_match && (dur_cnt != 32'h0000_0000);
    assign dur_plus = {1'b0, dur_cnt} + 33'h0_0000_0001;

    // ------------------------------------------------------------
    // burst edge detection and idle timing
    // ------------------------------------------------------------
    assign src_now =
        chan[ctrl[`PDT_CTRL_SRC_MSB:`PDT_CTRL_SRC_LSB]];
    assign src_trans = src_now != src_prev;
    assign edge_hit = src_trans && (src_now == pol_rise);
    assign idle_done = idle_cnt >= burst_idle;
    assign next_edge_cnt = idle_done ? 32'h0000_0001 :
        edge_cnt + 32'h0000_0001;

    // idle counter starts saturated: first edge opens a burst
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_prev <= 1'b0;
            idle_cnt <= 32'hffff_ffff;
            edge_cnt <= '0;
        end else begin
            src_prev <= src_now;
            if (src_trans) begin
                idle_cnt <= '0;
            end else if (idle_cnt != 32'hffff_ffff) begin
                idle_cnt <= idle_cnt + 32'h0000_0001;
            end
            // the first transition after quiet opens a new burst even
            // when it has the wrong polarity, so falling counts restart
            if (edge_hit) begin
                edge_cnt <= next_edge_cnt;
            end else if (src_trans && idle_done) begin
                edge_cnt <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // trigger decision
    // ------------------------------------------------------------
    always_comb begin
        next_trig = 1'b0;
        if (!trig_en) begin
            next_trig = 1'b0;
        end else if (burst_mode) begin
            next_trig = edge_hit && (next_edge_cnt == burst_ord);
        end else begin
            case (qual)
                PDT_QUAL_LONGER, PDT_QUAL_TIMEOUT: begin
                    // timeout shares the longer-than limit
                    next_trig = pat_match &&
                        (dur_plus == {1'b0, longer_lim});
                end
                PDT_QUAL_SHORTER: begin
                    next_trig = match_end &&
                        (dur_cnt < shorter_lim);
                end
                PDT_QUAL_WITHIN: begin
                    next_trig = match_end && (dur_cnt >= win_lo) &&
                        (dur_cnt <= win_hi);
                end
                PDT_QUAL_OUTSIDE: begin
                    next_trig = match_end && ((dur_cnt < win_lo) ||
                        (dur_cnt > win_hi));
                end
                default: begin
                    next_trig = 1'b0;
                end
            endcase
        end
    end

    // single-cycle trigger pulse and its running count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trig_out <= 1'b0;
            trig_cnt <= '0;
        end else begin
            trig_out <= next_trig;
            if (next_trig) begin
                trig_cnt <= trig_cnt + 32'h0000_0001;
            end
        end
    end

    // ------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------
    assign addr_ok = hsel && htrans[1] && hready;

    // writes take no wait; reads add one wait so that a read right
    // after a write returns the freshly written value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q <= '0;
            hreadyout <= 1'b1;
            hrdata <= '0;
            hresp <= 1'b0;
        end else begin
            wr_pend <= addr_ok && hwrite;
            rd_pend <= addr_ok && !hwrite;
            if (addr_ok) begin
                addr_q <= haddr[7:0];
            end
            if (addr_ok && !hwrite) begin
                hreadyout <= 1'b0;
            end else if (rd_pend) begin
                hreadyout <= 1'b1;
                hrdata <= rd_mux;
            end
        end
    end

    // read decode; unmapped offsets read zero
    always_comb begin
        if (addr_q == `PDT_OFS_CTRL) begin
            rd_mux = ctrl;
        end else if (addr_q == `PDT_OFS_PAT_VALUE) begin
            rd_mux = pat_value;
        end else if (addr_q == `PDT_OFS_PAT_MASK) begin
            rd_mux = pat_mask;
        end else if (addr_q == `PDT_OFS_LONGER) begin
            rd_mux = longer_lim;
        end else if (addr_q == `PDT_OFS_SHORTER) begin
            rd_mux = shorter_lim;
        end else if (addr_q == `PDT_OFS_WIN_LO) begin
            rd_mux = win_lo;
        end else if (addr_q == `PDT_OFS_WIN_HI) begin
            rd_mux = win_hi;
        end else if (addr_q == `PDT_OFS_BURST_ORD) begin
            rd_mux = burst_ord;
        end else if (addr_q == `PDT_OFS_BURST_IDLE) begin
            rd_mux = burst_idle;
        end else if (addr_q == `PDT_OFS_STATUS) begin
            rd_mux = {edge_cnt[15:0], 15'h0000, pat_match};
        end else if (addr_q == `PDT_OFS_TRIG_CNT) begin
            rd_mux = trig_cnt;
        end else begin
            rd_mux = '0;
        end
    end

    // clamped window values of the current write
    assign new_lo = clamp(hwdata, WIN_LO_MIN_CYC, WIN_LO_MAX_CYC);
    assign new_hi = clamp(hwdata, WIN_HI_MIN_CYC, WIN_HI_MAX_CYC);

    // register writes in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= `PDT_CTRL_RST;
            pat_value <= '0;
            pat_mask <= '0;
            longer_lim <= LONGER_MIN_CYC;
            shorter_lim <= SHORTER_MIN_CYC;
            win_lo <= WIN_LO_MIN_CYC;
            win_hi <= WIN_HI_MIN_CYC;
            burst_ord <= `PDT_BURST_ORD_RST;
            burst_idle <= IDLE_MIN_CYC;
        end else if (wr_pend) begin
            if (addr_q == `PDT_OFS_CTRL) begin
                ctrl <= hwdata;
            end else if (addr_q == `PDT_OFS_PAT_VALUE) begin
                pat_value <= hwdata;
            end else if (addr_q == `PDT_OFS_PAT_MASK) begin
                pat_mask <= hwdata;
            end else if (addr_q == `PDT_OFS_LONGER) begin
                longer_lim <= clamp(hwdata, LONGER_MIN_CYC,
                    LONGER_MAX_CYC);
            end else if (addr_q == `PDT_OFS_SHORTER) begin
                shorter_lim <= clamp(hwdata, SHORTER_MIN_CYC,
                    SHORTER_MAX_CYC);
            end else if (addr_q == `PDT_OFS_WIN_LO) begin
                if (new_lo > win_hi) begin
                    win_lo <= win_hi;
                    win_hi <= new_lo;
                end else begin
                    win_lo <= new_lo;
                end
            end else if (addr_q == `PDT_OFS_WIN_HI) begin
                if (new_hi < win_lo) begin
                    win_hi <= win_lo;
                    win_lo <= new_hi;
                end else begin
                    win_hi <= new_hi;
                end
            end else if (addr_q == `PDT_OFS_BURST_ORD) begin
                burst_ord <= hwdata;
            end else if (addr_q == `PDT_OFS_BURST_IDLE) begin
                burst_idle <= clamp(hwdata, IDLE_MIN_CYC,
                    IDLE_MAX_CYC);
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_win_order: assert property (@(posedge hclk) disable iff (!hresetn)
        win_lo <= win_hi)
        else $error("window lower bound above upper bound");

    a_mask_hit: assert property (@(posedge hclk) disable iff (!hresetn)
        (pat_mask == 32'h0000_0000) |-> pat_match)
        else $error("empty mask did not match");

    a_val_miss: assert property (@(posedge hclk) disable iff (!hresetn)
        ((pat_mask & (chan ^ pat_value)) != 32'h0000_0000) |-> !pat_match)
        else $error("mismatching channel still matched");

    a_long_fire: assert property (@(posedge hclk) disable iff (!hresetn)
        (trig_en && !burst_mode && (qual == PDT_QUAL_LONGER) && pat_match
        && (dur_plus == {1'b0, longer_lim})) |=> trig_out)
        else $error("longer-than limit reached without trigger");

    a_short_end: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(trig_out) && $past(trig_en) && !$past(burst_mode)
        && ($past(qual) == PDT_QUAL_SHORTER)
        |-> $past(match_end) && ($past(dur_cnt) < $past(shorter_lim)))
        else $error("shorter-than trigger without short pattern");

    a_win_only: assert property (@(posedge hclk) disable iff (!hresetn)
        (trig_en && !burst_mode && (qual == PDT_QUAL_WITHIN) && match_end
        && (dur_cnt > win_hi)) |=> !trig_out)
        else $error("within-window trigger outside window");

    a_trig_one: assert property (@(posedge hclk) disable iff (!hresetn)
        trig_out |=> !trig_out)
        else $error("trigger pulse longer than one cycle");

    a_burst_nth: assert property (@(posedge hclk) disable iff (!hresetn)
        trig_out && $past(burst_mode) |-> $past(edge_hit)
        && (edge_cnt == $past(burst_ord)))
        else $error("burst trigger on wrong edge");

    a_idle_rst: assert property (@(posedge hclk) disable iff (!hresetn)
        (edge_hit && idle_done) |=> (edge_cnt == 32'h0000_0001))
        else $error("edge count not restarted after idle");

    a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        (addr_ok && !hwrite) |=> !hreadyout ##1 hreadyout)
        else $error("read did not take exactly one wait");
endmodule

// File: tb/pdt_probe.sv
// ----------------------------------------------------------------
// probe channels feeding the trigger pins
// ----------------------------------------------------------------
module pdt_probe (
    input wire logic hclk,
    input wire logic [20:0] level, // wanted channel levels, pattern order
    output logic [15:0] dig_in = 16'h0000, // digital channels
    output logic [3:0] ana_in = 4'h0, // analog comparators
    output logic ext_in = 1'b0 // external trigger input
);
    timeunit 1ns;
    timeprecision 1ns;
    // pins move just after the edge, like a real acquired sample stream
    always @(posedge hclk) begin
        dig_in <= level[15:0];
        ana_in <= level[19:16];
        ext_in <= level[20];
    end
endmodule

// File: tb/pdt_trigger_test.sv
`include "pdt_regs.svh"
module pdt_trigger_test;
    timeunit 1ns;
    timeprecision 1ns;
    import pdt_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    typedef struct {logic [2:0] q; int hold; int exp;} pdt_row_t;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, junk;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2; // word transfers only
    logic [20:0] level = 21'h0; // probe request
    logic hreadyout, hresp, trig_out, ext_in;
    logic [15:0] dig_in;
    logic [3:0] ana_in;
    int failures = 0, comparisons = 0, total = 0, got;
    // masked match: bits 0,2,16,19 high, bit 1 low; 8..15 masked out
    localparam logic [20:0] ON = 21'h09ff05;
    localparam logic [20:0] OFF = 21'h08ff05; // analog 1 dropped
    pdt_row_t rows[16] = '{'{3'h0, 4, 0}, '{3'h0, 5, 1}, '{3'h0, 9, 1},
        '{3'h1, 1, 1}, '{3'h1, 4, 1}, '{3'h1, 5, 0}, '{3'h2, 2, 0},
        '{3'h2, 3, 1}, '{3'h2, 5, 1}, '{3'h2, 6, 0}, '{3'h3, 2, 1},
        '{3'h3, 3, 0}, '{3'h3, 6, 1}, '{3'h4, 4, 0}, '{3'h4, 5, 1},
        '{3'h5, 5, 0}};
    // ------------------------------------------------------------
    // design and probe model; small limits keep the run short
    // ------------------------------------------------------------
    pdt_trigger #(.VARIANT(PDT_VAR_4A16D), .LONGER_MAX_CYC(32'd64),
        .SHORTER_MAX_CYC(32'd64), .WIN_LO_MAX_CYC(32'd60),
        .WIN_HI_MAX_CYC(32'd64), .IDLE_MAX_CYC(32'd64)) u_pdt_trigger (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .dig_in(dig_in), .ana_in(ana_in), .ext_in(ext_in),
        .trig_out(trig_out));
    pdt_probe u_pdt_probe (.hclk(hclk), .level(level), .dig_in(dig_in),
        .ana_in(ana_in), .ext_in(ext_in));
    initial begin
        forever #25 hclk = ~hclk;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic print_verdict;
        if (failures == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // bounded wait for hready; a hang ends the run as a failure
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            failures++;
            print_verdict;
        end
    endtask
    // one single word transfer; read data taken at the closing edge
    task automatic ahb(logic wr, logic [7:0] a, logic [31:0] d,
        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        wait_rdy;
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_rdy;
        rd = hrdata;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] exp);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        check("reg", r, exp);
    endtask
    task automatic wr_rd(logic [7:0] a, logic [31:0] d, logic [31:0] exp);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
        rd(a, exp);
    endtask
    // hold a level for n cycles, counting trigger pulses on the way
    task automatic step(logic [20:0] lv, int n, inout int cnt);
        level <= lv;
        repeat (n) begin
            @(posedge hclk);
            cnt += int'(trig_out === 1'b1);
        end
    endtask
    // n pulses on analog 1, each high and low two cycles, then quiet
    task automatic burst(int n, int exp);
        got = 0;
        repeat (n) begin
            step(21'h010000, 2, got);
            step(21'h0, 2, got);
        end
        step(21'h0, 12, got);
        check("burst", 32'(got), 32'(exp));
        total += exp;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge hclk);
        check("ready", {31'h0, hreadyout}, 32'h1);
        check("trig", {31'h0, trig_out}, 32'h0);
        hresetn <= 1'b1;
        rd(`PDT_OFS_CTRL, 32'h0);
        rd(`PDT_OFS_BURST_ORD, 32'h1);
        rd(`PDT_OFS_LONGER, 32'h1);
        wr_rd(`PDT_OFS_PAT_VALUE, 32'h0009_0005, 32'h0009_0005);
        wr_rd(`PDT_OFS_PAT_MASK, 32'h0009_0007, 32'h0009_0007);
        wr_rd(`PDT_OFS_LONGER, 32'h5, 32'h5);
        wr_rd(`PDT_OFS_SHORTER, 32'h5, 32'h5);
        wr_rd(`PDT_OFS_WIN_HI, 32'h5, 32'h5);
        wr_rd(`PDT_OFS_WIN_LO, 32'h3, 32'h3);
        // each qualifier around its limits, then the unused code 5
        foreach (rows[i]) begin
            ahb(1'b1, `PDT_OFS_CTRL, {27'h0, rows[i].q, 2'b01}, junk);
            got = 0;
            step(ON, rows[i].hold, got);
            step(OFF, 10, got);
            check("qual", 32'(got), 32'(rows[i].exp));
            total += rows[i].exp;
        end
        // a low-required channel held high spoils the match
        ahb(1'b1, `PDT_OFS_CTRL, 32'h1, junk);
        got = 0;
        step(ON | 21'h2, 9, got);
        step(OFF, 10, got);
        check("value", 32'(got), 32'h0);
        // disabled block never fires
        ahb(1'b1, `PDT_OFS_CTRL, 32'h0, junk);
        got = 0;
        step(ON, 9, got);
        step(OFF, 10, got);
        check("off", 32'(got), 32'h0);
        // burst mode on analog 1, third rising edge, idle four cycles
        ahb(1'b1, `PDT_OFS_BURST_ORD, 32'h3, junk);
        ahb(1'b1, `PDT_OFS_BURST_IDLE, 32'h4, junk);
        ahb(1'b1, `PDT_OFS_CTRL, 32'h0000_1023, junk);
        burst(2, 0);
        burst(2, 0);
        burst(3, 1);
        burst(5, 1);
        ahb(1'b1, `PDT_OFS_CTRL, 32'h0000_1003, junk);
        burst(3, 1);
        ahb(1'b1, `PDT_OFS_BURST_ORD, 32'h0, junk);
        burst(3, 0);
        // read-only count, bound swap, clamps, unmapped word
        rd(`PDT_OFS_TRIG_CNT, 32'(total));
        rd(`PDT_OFS_STATUS, 32'h0003_0000);
        wr_rd(`PDT_OFS_TRIG_CNT, 32'h0, 32'(total));
        wr_rd(`PDT_OFS_WIN_LO, 32'h8, 32'h5);
        rd(`PDT_OFS_WIN_HI, 32'h8);
        wr_rd(`PDT_OFS_WIN_HI, 32'h2, 32'h5);
        rd(`PDT_OFS_WIN_LO, 32'h2);
        wr_rd(`PDT_OFS_LONGER, 32'h0, 32'h1);
        wr_rd(`PDT_OFS_LONGER, 32'd1000, 32'd64);
        wr_rd(8'h2c, 32'hffff_ffff, 32'h0);
        wr_rd(`PDT_OFS_PAT_MASK, 32'hffff_ffff, 32'hffff_ffff);
        check("resp", {31'h0, hresp}, 32'h0);
        print_verdict;
    end
endmodule
